//--- include/rcs_pkg.sv
// Constants for the run-command source and ramp block
package rcs_pkg;
   // --------
   // Clock and serial link
   // --------
   localparam int          CLK_HZ       = 50_000_000;
   localparam int          BAUD         = 9600;
   localparam int          BIT_CYC      = CLK_HZ / BAUD;     // rounded down
   localparam int          GAP_BITS     = 35;                // 3.5 characters
   localparam int          GAP_CYC      = GAP_BITS * BIT_CYC;
   localparam int          TENTH_MS     = 100;               // ramp time unit, ms
   localparam int          TENTH_CYC    = CLK_HZ / 1000 * TENTH_MS;
   localparam logic [7:0]  NODE_ADDR    = 8'h01;
   localparam logic [7:0]  FN_WRITE_ONE = 8'h06;
   localparam logic [15:0] CRC_INIT     = 16'hFFFF;
   localparam logic [15:0] CRC_POLY     = 16'hA001;
   localparam int          FRAME_LEN    = 8;
   // --------
   // Register map
   // --------
   localparam logic [15:0] ADDR_RUN_COMMAND = 16'h2501;
   localparam logic [15:0] ADDR_FREQ_REF    = 16'h2502;
   localparam int          CMD_FWD_BIT      = 0;
   localparam int          CMD_REV_BIT      = 1;
   localparam logic [15:0] FREQ_REF_MAX     = 16'h9C40;  // 400.00 Hz
   // --------
   // Sources, presets, limits
   // --------
   typedef enum logic [1:0] {
      RCS_SRC_KEYPAD = 2'b00,
      RCS_SRC_TERM   = 2'b01,
      RCS_SRC_SERIAL = 2'b10,
      RCS_SRC_SEQ    = 2'b11
   } rcs_src_e;
   localparam logic [7:0]  FN_DIRECTION_KEY    = 8'h1A;      // function code 26
   localparam logic [15:0] CUR_MIN       = 16'h0001;   // 0.01 A
   localparam logic [15:0] CUR_MAX       = 16'hEA60;   // 600.00 A
   localparam logic [15:0] PWR_MAX       = 16'hEA60;   // 600.00 kW
   localparam logic [15:0] HP_TO_KW_MILLI = 16'h02EA;  // 0.746 kW per hp
   localparam logic [15:0] DU_RPM_LO = 16'h0002;
   localparam logic [15:0] DU_RPM_HI = 16'h0027;
   localparam logic [15:0] DU_INT_HI = 16'h270F;
   localparam logic [15:0] DU_D1_LO  = 16'h2711;
   localparam logic [15:0] DU_D1_HI  = 16'h4E1F;
   localparam logic [15:0] DU_D2_LO  = 16'h4E21;
   localparam logic [15:0] DU_D2_HI  = 16'h752F;
   localparam logic [15:0] DU_D3_LO  = 16'h7531;
   localparam logic [15:0] DU_D3_HI  = 16'h9C3F;
   typedef enum logic [2:0] {
      RCS_DU_HZ = 3'b000, RCS_DU_PCT = 3'b001, RCS_DU_RPM = 3'b010,
      RCS_DU_SCALE = 3'b011, RCS_DU_BAD = 3'b100
   } rcs_du_e;
endpackage

//--- hw/rcs_top.sv
// Run-command source selection, serial command port and frequency ramp
//
// Functional notes
// R1: run source select: 0 keypad, 1 terminals, 2 serial, 3 sequencer.
// R2: 16-bit command register at 2501h; bit0 forward, bit1 reverse.
// R3: writing zero to the command register stops the drive under serial control.
// R4: serial defaults to node 1, 9600 bit/s, 8 data, 1 stop, no parity.
// R5: frames end in CRC16; received CRC checked, sent CRC generated.
// R6: keypad run key starts forward; direction key reverses direction. Code: run key starts in the last latched keypad direction.
// R7: reverse inhibit refuses any reverse run.
// R8: stop uses stop method; default decelerate to zero.
// R9: preset 3, 5 or 7 gives three-wire: in1 run, in2 stop, in7 direction. Code: three-wire also needs terminal 7 function 26.
// R10: terminal 7 function 26 makes it the forward/reverse selector.
// R11: display code 0 Hz, 1 percent, 2..39 rpm, 40..9999 integer scale.
// R12: display codes 10001.., 20001.., 30001.. give 1, 2, 3 decimals.
// R13: accel time is zero to max; decel time is max to zero.
// R14: ramp rate follows max frequency, so smaller targets arrive sooner.
// R15: torque or stall limit holds the ramp, lengthening it.
// R16: rated current accepted from 0.01 A to 600.00 A.
// R17: rated power accepted up to 600.00 kW.
// R18: frequency reference register at 2502h, 0.01 Hz units, up to 400.00 Hz.
// R19: two-wire terminal: run while contact closed, stop when open.
// R20: command value with both bits set means reverse run.
`timescale 1ns/1ps
module rcs_top
   import rcs_pkg::*;
#(
   parameter int BIT_CYC_P   = rcs_pkg::BIT_CYC,
   parameter int GAP_CYC_P   = rcs_pkg::GAP_CYC,
   parameter int TENTH_CYC_P = rcs_pkg::TENTH_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        ser_rx,
   output logic             ser_tx,
   output logic             ser_tx_oe,
   input  wire logic        key_run,
   input  wire logic        key_stop,
   input  wire logic        direction_key,
   input  wire logic        terminal_in1,
   input  wire logic        terminal_in2,
   input  wire logic        terminal_in7,
   input  wire logic [1:0]  run_source_select,
   input  wire logic        reverse_inhibit,
   input  wire logic        stop_method_select,
   input  wire logic [3:0]  init_preset,
   input  wire logic [7:0]  terminal7_function,
   input  wire logic        seq_run,
   input  wire logic        seq_rev,
   input  wire logic [15:0] accel_time,
   input  wire logic [15:0] decel_time,
   input  wire logic [15:0] max_freq,
   input  wire logic        limit_active,
   input  wire logic [15:0] display_unit_select,
   input  wire logic [15:0] motor_rated_current,
   input  wire logic [15:0] motor_rated_power,
   output logic [15:0]      out_freq,
   output logic             dir_rev,
   output logic             running,
   output logic [2:0]       disp_mode,
   output logic [1:0]       disp_decimals,
   output logic             current_ok,
   output logic             power_ok
);
   import rcs_pkg::*;

   // --------
   // State
   // --------
   typedef struct packed {
      logic [6:0]      sy1;
      logic [6:0]      sy2;
      logic [6:0]      sy3;
      logic            rx_busy;
      logic [15:0]     rx_cnt;
      logic [3:0]      rx_bit;
      logic [7:0]      rx_sh;
      logic [23:0]     gap;
      logic [3:0]      nbytes;
      logic [7:0][7:0] buff;
      logic [15:0]     crc;
      logic [15:0]     cmd;
      logic [15:0]     fref;
      logic            tx_busy;
      logic [9:0]      tx_sh;
      logic [3:0]      tx_bit;
      logic [15:0]     tx_cnt;
      logic [3:0]      tx_idx;
      logic [15:0]     tx_crc;
      logic            tx;
      logic            tx_oe;
      logic            kp_run;
      logic            kp_rev;
      logic            t3_run;
      logic [15:0]     freq;
      logic            dir;
      logic            run;
      logic [39:0]     acc;
      logic [2:0]      du;
      logic [1:0]      dec;
      logic            cur_ok;
      logic            pwr_ok;
   } rcs_state_s;

   rcs_state_s st;
   rcs_state_s next_st;

   // CRC16 update of one byte, reflected polynomial
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   logic [6:0]  pin_now;
   logic [6:0]  rise;
   logic        rx_s;
   logic        want_run;
   logic        want_rev;
   logic        three_wire;
   logic [15:0] target;
   logic [39:0] lim;
   logic [7:0]  tx_byte;
   logic        frame_ok;

   assign pin_now = {terminal_in7, terminal_in2, terminal_in1, direction_key, key_stop, key_run, ser_rx};

   // --------
   // Next-state logic
   // --------
   always_comb begin
      next_st = st;
      // Two-stage input synchronisers, third stage for edges
      next_st.sy1 = pin_now;
      next_st.sy2 = st.sy1;
      next_st.sy3 = st.sy2;
      rise = st.sy2 & ~st.sy3;
      rx_s = st.sy2[0];
      frame_ok = 1'b0;

      // Serial receiver, 8 data bits, one stop bit, no parity
      // R4: fixed default link format
      if (st.gap != 24'h000000) begin
         next_st.gap = st.gap - 24'h000001;
      end else begin
         next_st.nbytes = 4'h0;
         next_st.crc = CRC_INIT;
      end
      if (!st.rx_busy) begin
         if (!rx_s) begin
            next_st.rx_busy = 1'b1;
            next_st.rx_cnt = 16'(BIT_CYC_P / 2);
            next_st.rx_bit = 4'h0;
         end
      end else if (st.rx_cnt != 16'h0000) begin
         next_st.rx_cnt = st.rx_cnt - 16'h0001;
      end else begin
         next_st.rx_cnt = 16'(BIT_CYC_P - 1);
         next_st.rx_bit = st.rx_bit + 4'h1;
         if (st.rx_bit == 4'h0 && rx_s) begin
            next_st.rx_busy = 1'b0;          // False start
         end else if (st.rx_bit < 4'h9) begin
            next_st.rx_sh = {rx_s, st.rx_sh[7:1]};
         end else begin
            next_st.rx_busy = 1'b0;
            next_st.gap = 24'(GAP_CYC_P);
            if (rx_s && st.nbytes < 4'(FRAME_LEN)) begin
               next_st.buff[st.nbytes[2:0]] = st.rx_sh;
               next_st.nbytes = st.nbytes + 4'h1;
               // R5: running CRC, residue zero over a whole frame
               next_st.crc = crc_byte(st.crc, st.rx_sh);
               frame_ok = (st.nbytes == 4'(FRAME_LEN - 1))
                          && (crc_byte(st.crc, st.rx_sh) == 16'h0000);
            end
         end
      end

      // Register write on a whole, valid frame for this node
      if (frame_ok && st.buff[0] == NODE_ADDR && st.buff[1] == FN_WRITE_ONE
          && !st.tx_busy) begin
         // R2: command register write
         if ({st.buff[2], st.buff[3]} == ADDR_RUN_COMMAND) begin
            next_st.cmd = {st.buff[4], st.buff[5]};
         end
         // R18: frequency reference, clamped to its range
         if ({st.buff[2], st.buff[3]} == ADDR_FREQ_REF) begin
            next_st.fref = ({st.buff[4], st.buff[5]} > FREQ_REF_MAX)
                           ? FREQ_REF_MAX : {st.buff[4], st.buff[5]};
         end
         next_st.tx_busy = 1'b1;
         next_st.tx_idx = 4'h0;
         next_st.tx_bit = 4'hA;
         next_st.tx_cnt = 16'h0000;
         next_st.tx_crc = CRC_INIT;
      end

      // Echo reply transmitter with freshly generated CRC
      tx_byte = (st.tx_idx < 4'h6) ? st.buff[st.tx_idx[2:0]]
              : (st.tx_idx == 4'h6) ? st.tx_crc[7:0] : st.tx_crc[15:8];
      if (st.tx_busy) begin
         next_st.tx_oe = 1'b1;
         if (st.tx_cnt != 16'h0000) begin
            next_st.tx_cnt = st.tx_cnt - 16'h0001;
         end else if (st.tx_bit == 4'hA) begin
            if (st.tx_idx == 4'(FRAME_LEN)) begin
               next_st.tx_busy = 1'b0;
               next_st.tx_oe = 1'b0;
            end else begin
               // R5: reply CRC generated byte by byte
               next_st.tx_sh = {1'b1, tx_byte, 1'b0};
               if (st.tx_idx < 4'h6) begin
                  next_st.tx_crc = crc_byte(st.tx_crc, tx_byte);
               end
               next_st.tx_idx = st.tx_idx + 4'h1;
               next_st.tx_bit = 4'h0;
            end
         end else begin
            next_st.tx = st.tx_sh[0];
            next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
            next_st.tx_bit = st.tx_bit + 4'h1;
            next_st.tx_cnt = 16'(BIT_CYC_P - 1);
         end
      end else begin
         next_st.tx = 1'b1;
      end

      // Keypad latch
      // R6: run key starts in the latched kp_rev direction (forward after reset), direction key toggles
      if (rise[1]) begin
         next_st.kp_run = 1'b1;
      end
      if (rise[3]) begin
         next_st.kp_rev = ~st.kp_rev & ~reverse_inhibit;
      end
      if (rise[2]) begin
         next_st.kp_run = 1'b0;
      end

      // R9: three-wire preset; R10: terminal 7 as direction selector
      three_wire = (init_preset == 4'h3 || init_preset == 4'h5 || init_preset == 4'h7)
                   && terminal7_function == FN_DIRECTION_KEY;
      if (rise[4]) begin
         next_st.t3_run = 1'b1;
      end
      if (st.sy2[5]) begin
         next_st.t3_run = 1'b0;            // Stop button wins
      end

      // R1: pick the command source
      case (rcs_src_e'(run_source_select))
         RCS_SRC_KEYPAD: begin
            want_run = st.kp_run;
            want_rev = st.kp_rev;
         end
         RCS_SRC_TERM: begin
            if (three_wire) begin
               want_run = st.t3_run;
               want_rev = st.sy2[6];
            end else begin
               // R19: maintained contacts, in1 forward, in2 reverse
               want_run = st.sy2[4] | st.sy2[5];
               want_rev = st.sy2[5] & ~st.sy2[4];
            end
         end
         RCS_SRC_SERIAL: begin
            // R3: zero stops; R20: both bits mean reverse
            want_run = st.cmd[CMD_FWD_BIT] | st.cmd[CMD_REV_BIT];
            want_rev = st.cmd[CMD_REV_BIT];
         end
         RCS_SRC_SEQ: begin
            want_run = seq_run;
            want_rev = seq_rev;
         end
         default: begin
            want_run = 1'b0;
            want_rev = 1'b0;
         end
      endcase
      // R7: reverse refused from any source
      if (reverse_inhibit && want_rev) begin
         want_run = 1'b0;
      end

      // Target: reference when running in the held direction, else zero
      target = (st.fref > max_freq) ? max_freq : st.fref;
      if (!want_run || want_rev != st.dir) begin
         target = 16'h0000;
      end
      if (st.freq == 16'h0000 && want_run) begin
         next_st.dir = want_rev;
      end

      // R13: time base; R14: step by max frequency per clock
      lim = (st.freq < target) ? 40'(accel_time) * 40'(TENTH_CYC_P)
                               : 40'(decel_time) * 40'(TENTH_CYC_P);
      if (!want_run && stop_method_select) begin
         // R8: coast stop drops output at once
         next_st.freq = 16'h0000;
         next_st.acc = 40'h0000000000;
      end else if (st.freq == target) begin
         next_st.acc = 40'h0000000000;
      end else if (!limit_active) begin
         // R15: ramp held while a limit is active
         if (st.acc + 40'(max_freq) >= lim) begin
            next_st.acc = st.acc + 40'(max_freq) - lim;
            next_st.freq = (st.freq < target) ? st.freq + 16'h0001 : st.freq - 16'h0001;
         end else begin
            next_st.acc = st.acc + 40'(max_freq);
         end
      end
      next_st.run = want_run | (st.freq != 16'h0000);

      // R11, R12: display unit decode
      next_st.dec = 2'b00;
      if (display_unit_select == 16'h0000) begin
         next_st.du = RCS_DU_HZ;
         next_st.dec = 2'b10;
      end else if (display_unit_select == 16'h0001) begin
         next_st.du = RCS_DU_PCT;
         next_st.dec = 2'b10;
      end else if (display_unit_select <= DU_RPM_HI) begin
         next_st.du = RCS_DU_RPM;
      end else if (display_unit_select <= DU_INT_HI) begin
         next_st.du = RCS_DU_SCALE;
      end else if (display_unit_select >= DU_D1_LO && display_unit_select <= DU_D1_HI) begin
         next_st.du = RCS_DU_SCALE;
         next_st.dec = 2'b01;
      end else if (display_unit_select >= DU_D2_LO && display_unit_select <= DU_D2_HI) begin
         next_st.du = RCS_DU_SCALE;
         next_st.dec = 2'b10;
      end else if (display_unit_select >= DU_D3_LO && display_unit_select <= DU_D3_HI) begin
         next_st.du = RCS_DU_SCALE;
         next_st.dec = 2'b11;
      end else begin
         next_st.du = RCS_DU_BAD;
      end

      // R16: current range; R17: power range
      next_st.cur_ok = motor_rated_current >= CUR_MIN && motor_rated_current <= CUR_MAX;
      next_st.pwr_ok = motor_rated_power <= PWR_MAX;
   end

   // --------
   // State register
   // --------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.sy1 <= 7'h01;
         st.sy2 <= 7'h01;
         st.sy3 <= 7'h01;
         st.crc <= CRC_INIT;
         st.tx <= 1'b1;
         st.du <= RCS_DU_HZ;
      end else begin
         st <= next_st;
      end
   end

   assign ser_tx        = st.tx;
   assign ser_tx_oe     = st.tx_oe;
   assign out_freq      = st.freq;
   assign dir_rev       = st.dir;
   assign running       = st.run;
   assign disp_mode     = st.du;
   assign disp_decimals = st.dec;
   assign current_ok    = st.cur_ok;
   assign power_ok      = st.pwr_ok;
endmodule

//--- tb/rcs_monitor.sv
// Port-level assertions for the run-command source and ramp block
`timescale 1ns/1ps
module rcs_monitor
   import rcs_pkg::*;
#(
   parameter int BIT_CYC_P = 16
) (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        ser_tx,
   input wire logic        ser_tx_oe,
   input wire logic        reverse_inhibit,
   input wire logic        limit_active,
   input wire logic        stop_method_select,
   input wire logic [15:0] display_unit_select,
   input wire logic [15:0] out_freq,
   input wire logic        dir_rev,
   input wire logic        running,
   input wire logic [2:0]  disp_mode,
   input wire logic [1:0]  disp_decimals
);
   int oe_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // --------
   // Helper logic and sequences
   // --------
   // Counts cycles of the current reply window
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         oe_cnt <= 0;
      end else begin
         oe_cnt <= ser_tx_oe ? oe_cnt + 1 : 0;
      end
   end
   sequence s_limit_held;
      limit_active [*4];
   endsequence
   sequence s_du_steady;
      $stable(display_unit_select) [*3];
   endsequence
   sequence s_inhibit_held;
      reverse_inhibit [*4];
   endsequence
   // --------
   // Assertions
   // --------
   chk_tx_idle_high: assert property (!ser_tx_oe |-> ser_tx)
      else $error("tx line not idle high");
   chk_reply_start: assert property ($rose(ser_tx_oe) |-> ##[0:20] !ser_tx)
      else $error("reply start bit missing");
   chk_reply_length: assert property ($fell(ser_tx_oe) |-> $past(oe_cnt) >= 80 * BIT_CYC_P)
      else $error("reply window too short");
   chk_ramp_step: assert property (!$past(stop_method_select) |-> out_freq == $past(out_freq)
      || out_freq == $past(out_freq) + 16'h0001 || out_freq + 16'h0001 == $past(out_freq))
      else $error("frequency jumped");
   chk_limit_hold: assert property (s_limit_held |-> $stable(out_freq))
      else $error("ramp moved under limit");
   chk_dir_at_zero: assert property ($changed(dir_rev) |-> $past(out_freq) == 16'h0000)
      else $error("direction flipped while turning");
   chk_no_reverse: assert property (s_inhibit_held |-> !$rose(dir_rev))
      else $error("reverse while inhibited");
   chk_running_turn: assert property (out_freq != 16'h0000 |-> running)
      else $error("turning while not running");
   chk_rpm_mode: assert property (s_du_steady ##0 display_unit_select inside {[DU_RPM_LO:DU_RPM_HI]}
      |-> disp_mode == RCS_DU_RPM) else $error("rpm display code wrong");
   chk_one_decimal: assert property (s_du_steady ##0 display_unit_select inside {[DU_D1_LO:DU_D1_HI]}
      |-> disp_decimals == 2'h1) else $error("decimal count wrong");
endmodule

bind rcs_top rcs_monitor #(.BIT_CYC_P(BIT_CYC_P)) i_rcs_monitor (.clk_sys, .rstn, .ser_tx, .ser_tx_oe,
   .reverse_inhibit, .stop_method_select, .limit_active, .display_unit_select, .out_freq, .dir_rev,
   .running, .disp_mode, .disp_decimals);

//--- tb/rcs_master_model.sv
// Serial bus master model: writes registers, collects replies
`timescale 1ns/1ps
module rcs_master_model
   import rcs_pkg::*;
#(
   parameter int BIT_CYC_P = 16
) (
   input  wire logic clk_sys,
   input  wire logic ser_tx,
   input  wire logic ser_tx_oe,
   output logic      ser_rx
);
   logic [7:0] sent [8];
   logic [7:0] got [$];
   initial ser_rx = 1'b1;
   function automatic logic [15:0] crc16(input int n);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, sent[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
         end
      end
      return c;
   endfunction
   // One byte, start bit, LSB first, stop bit
   task automatic put_byte(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         ser_rx <= f[i];
         repeat (BIT_CYC_P) @(posedge clk_sys);
      end
   endtask
   // write frame, CRC low byte first, optionally corrupted
   task automatic write_reg(input logic [15:0] a, input logic [15:0] d, input logic bad);
      logic [15:0] c;
      {sent[0], sent[1], sent[2], sent[3], sent[4], sent[5]} = {NODE_ADDR, FN_WRITE_ONE, a, d};
      c = crc16(6) ^ {15'h0000, bad};
      {sent[7], sent[6]} = c;
      for (int i = 0; i < 8; i++) begin
         put_byte(sent[i]);
      end
   endtask
   // Samples reply bytes mid-bit
   initial begin
      logic [7:0] d;
      forever begin
         wait (ser_tx_oe === 1'b1);
         @(negedge ser_tx);
         repeat (BIT_CYC_P / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC_P) @(posedge clk_sys);
            d[i] = ser_tx;
         end
         repeat (BIT_CYC_P) @(posedge clk_sys);
         got.push_back(d);
      end
   end
endmodule

//--- tb/run_command_source_and_ramp_tb.sv
// Self-checking bench for the run-command source and ramp block
`timescale 1ns/1ps
module run_command_source_and_ramp_tb;
   import rcs_pkg::*;
   localparam int BC = 16;
   localparam int GAP = 600;
   logic        clk_sys, rstn, ser_rx, ser_tx, ser_tx_oe, dir_rev, running, current_ok, power_ok;
   logic        key_run, key_stop, direction_key, terminal_in1, terminal_in2, terminal_in7;
   logic        reverse_inhibit, stop_method_select, seq_run, seq_rev, limit_active;
   logic [1:0]  run_source_select, disp_decimals;
   logic [2:0]  disp_mode;
   logic [3:0]  init_preset;
   logic [7:0]  terminal7_function;
   logic [15:0] accel_time, decel_time, max_freq, display_unit_select, motor_rated_current;
   logic [15:0] motor_rated_power, out_freq, f0, v, c, p;
   logic [15:0] du_corner [14] = '{16'h0000, 16'h0001, 16'h0002, 16'h0027, 16'h0028, 16'h270F, 16'h2710,
                                   16'h2711, 16'h4E1F, 16'h4E21, 16'h752F, 16'h7531, 16'h9C3F, 16'h9C40};
   logic [15:0] lim_corner [4] = '{16'h0000, 16'h0001, 16'hEA60, 16'hEA61};
   int          mismatches = 0, n_tests = 0, cyc = 0, seed, t0;
   rcs_top #(.BIT_CYC_P(BC), .GAP_CYC_P(GAP), .TENTH_CYC_P(10)) i_rcs_top (.clk_sys, .rstn, .ser_rx, .ser_tx,
      .ser_tx_oe, .key_run, .key_stop, .direction_key, .terminal_in1, .terminal_in2, .terminal_in7,
      .run_source_select, .reverse_inhibit, .stop_method_select, .init_preset, .terminal7_function, .seq_run,
      .seq_rev, .accel_time, .decel_time, .max_freq, .limit_active, .display_unit_select, .motor_rated_current,
      .motor_rated_power, .out_freq, .dir_rev, .running, .disp_mode, .disp_decimals, .current_ok, .power_ok);
   rcs_master_model #(.BIT_CYC_P(BC)) i_rcs_master_model (.clk_sys, .ser_tx, .ser_tx_oe, .ser_rx);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Cuts a hang short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         mismatches++;
         print_verdict();
      end
   end
   // --------
   // Helpers
   // --------
   function automatic logic [1:0] du_dec(input logic [15:0] x);
      return x <= 16'h0001 ? 2'h2 : x >= DU_D3_LO ? 2'h3 : x >= DU_D2_LO ? 2'h2 : x >= DU_D1_LO ? 2'h1 : 2'h0;
   endfunction
   function automatic logic [2:0] du_mode(input logic [15:0] x);
      if (x <= 16'h0001) return 3'(x);
      if (x <= DU_RPM_HI) return RCS_DU_RPM;
      if (x <= DU_INT_HI || (du_dec(x) != 2'h0 && x <= DU_D3_HI && x % 10000 != 0)) return RCS_DU_SCALE;
      return RCS_DU_BAD;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wait_freq(input logic [15:0] f);
      for (int i = 0; i < 400 && out_freq !== f; i++) tick(1);
   endtask
   task automatic reply_check(input logic bad);
      for (int i = 0; i < 1500 && i_rcs_master_model.got.size() < 8; i++) tick(1);
      tick(GAP);
      check(16'(i_rcs_master_model.got.size()), bad ? 16'h0000 : 16'h0008);
      for (int k = 0; k < 8 && !bad; k++) check(i_rcs_master_model.got[k], i_rcs_master_model.sent[k]);
      i_rcs_master_model.got.delete();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // --------
   // Main sequence
   // --------
   initial begin
      seed = 32'h0000C60E;
      {rstn, key_run, key_stop, direction_key, terminal_in1, terminal_in2, terminal_in7} = '0;
      {reverse_inhibit, stop_method_select, seq_run, seq_rev, limit_active, init_preset} = '0;
      {terminal7_function, display_unit_select, motor_rated_power} = '0;
      run_source_select = RCS_SRC_SERIAL;
      {accel_time, decel_time, max_freq, motor_rated_current} = {16'h0014, 16'h0014, 16'h0064, 16'h0064};
      tick(20);
      rstn <= 1'b1;
      tick(3);
      check({ser_tx, ser_tx_oe, running}, 16'h0004);
      check(out_freq, 16'h0000);
      i_rcs_master_model.write_reg(ADDR_FREQ_REF, 16'h0032, 1'b0);
      reply_check(1'b0);
      i_rcs_master_model.write_reg(ADDR_RUN_COMMAND, 16'h0001, 1'b0);
      t0 = cyc;
      wait_freq(16'h0032);
      check((cyc - t0 >= 95) && (cyc - t0 <= 115), 16'h0001);
      check(dir_rev, 1'b0);
      reply_check(1'b0);
      i_rcs_master_model.write_reg(ADDR_RUN_COMMAND, 16'h0003, 1'b0);
      wait_freq(16'h0000);
      tick(4);
      check(dir_rev, 1'b1);
      reply_check(1'b0);
      i_rcs_master_model.write_reg(ADDR_RUN_COMMAND, 16'h0000, 1'b1);
      reply_check(1'b1);
      check(running, 1'b1);
      i_rcs_master_model.write_reg(ADDR_RUN_COMMAND, 16'h0000, 1'b0);
      wait_freq(16'h0000);
      tick(4);
      check(running, 1'b0);
      reply_check(1'b0);
      // Keypad: run forward, reverse, stop with ramp down
      run_source_select <= RCS_SRC_KEYPAD;
      key_run <= 1'b1;
      tick(4);
      key_run <= 1'b0;
      wait_freq(16'h0032);
      check(dir_rev, 1'b0);
      direction_key <= 1'b1;
      tick(4);
      direction_key <= 1'b0;
      for (int i = 0; i < 400 && dir_rev !== 1'b1; i++) tick(1);
      wait_freq(16'h0032);
      check(dir_rev, 1'b1);
      key_stop <= 1'b1;
      tick(4);
      key_stop <= 1'b0;
      tick(10);
      check(running && out_freq != 16'h0000, 16'h0001);
      wait_freq(16'h0000);
      tick(4);
      check(running, 1'b0);
      // Two-wire terminals, then reverse under inhibit
      run_source_select <= RCS_SRC_TERM;
      terminal_in1 <= 1'b1;
      tick(30);
      check({running, dir_rev}, 2'b10);
      terminal_in1 <= 1'b0;
      wait_freq(16'h0000);
      reverse_inhibit <= 1'b1;
      terminal_in2 <= 1'b1;
      tick(30);
      check({running, dir_rev}, 2'b00);
      {terminal_in2, reverse_inhibit} <= 2'b00;
      // Three-wire pushbuttons for every preset
      terminal7_function <= FN_DIRECTION_KEY;
      for (int k = 3; k <= 7; k += 2) begin
         init_preset <= 4'(k);
         stop_method_select <= (k == 5);
         terminal_in7 <= (k == 7);
         terminal_in1 <= 1'b1;
         tick(4);
         terminal_in1 <= 1'b0;
         tick(30);
         check({running, dir_rev}, {1'b1, k == 7});
         terminal_in2 <= 1'b1;
         tick(5);
         check(out_freq == 16'h0000, k == 5);
         terminal_in2 <= 1'b0;
         wait_freq(16'h0000);
         tick(4);
         check(running, 1'b0);
      end
      // Sequencer run with the ramp held by the limiter
      {init_preset, terminal_in7, stop_method_select} <= '0;
      run_source_select <= RCS_SRC_SEQ;
      seq_run <= 1'b1;
      tick(30);
      limit_active <= 1'b1;
      tick(4);
      f0 = out_freq;
      tick(20);
      check(out_freq, f0);
      check(running && f0 != 16'h0000, 16'h0001);
      {limit_active, seq_run} <= 2'b00;
      wait_freq(16'h0000);
      // Display codes and rated limits, corners then random
      for (int i = 0; i < 40; i++) begin
         v = (i < 14) ? du_corner[i] : 16'($random(seed));
         c = (i < 4) ? lim_corner[i] : 16'($random(seed));
         p = (i < 4) ? lim_corner[3 - i] : 16'($random(seed));
         {display_unit_select, motor_rated_current, motor_rated_power} <= {v, c, p};
         tick(4);
         check(disp_mode, du_mode(v));
         if (du_mode(v) != RCS_DU_BAD) check(disp_decimals, du_dec(v));
         check(current_ok, c >= CUR_MIN && c <= CUR_MAX);
         check(power_ok, p <= PWR_MAX);
      end
      print_verdict();
   end
endmodule
